// File: logic/tbod_decoder.v
// Transfer and branch opcode decoder with operand sequencing and cycle timing
`timescale 1ns/1ps
`include "tbod_map.vh"

module tbod_decoder
(
    input  wire        sys_clk,
    input  wire        rst_b,
    input  wire        clk_en,
    input  wire        fetch_valid,
    input  wire [7:0]  fetch_byte,
    input  wire        code_internal,
    input  wire        target_secondary,
    output reg         fetch_ready,
    output reg         pc_step,
    output reg  [4:0]  op_class,
    output reg  [2:0]  reg_sel,
    output reg  [1:0]  op_len,
    output reg  [2:0]  op_cycles,
    output reg  [7:0]  operand1,
    output reg  [7:0]  operand2,
    output reg         issue,
    output reg         busy
);

    // ==========================================================================
    // States
    localparam ST_OPC  = 2'h0;
    localparam ST_DEC  = 2'h1;
    localparam ST_OPND = 2'h2;
    localparam ST_EXEC = 2'h3;

    reg  [1:0] state;
    reg  [7:0] opc;
    reg  [1:0] got;
    reg  [2:0] cnt;
    reg  [2:0] next_cyc;
    wire [4:0] t_class;
    wire [1:0] t_len;
    wire [2:0] t_cyc;
    wire       t_valid;

    tbod_table u_table
    (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .clk_en   (clk_en),
        .load     (state == ST_OPC && fetch_valid),
        .opcode   (fetch_byte),
        .op_class (t_class),
        .op_len   (t_len),
        .op_cyc   (t_cyc),
        .op_valid (t_valid)
    );

    // ==========================================================================
    // External write timing depends on target space and where code runs
    always @*
    begin
        next_cyc = t_cyc;
        if (t_class == `TBOD_OP_XWR_RI)
            next_cyc = target_secondary ? `TBOD_CYC_XWR_RI_SEC :
                       code_internal ? `TBOD_CYC_XWR_RI_INT : `TBOD_CYC_XWR_RI_EXT;
        else if (t_class == `TBOD_OP_XWR_DP)
            next_cyc = target_secondary ? `TBOD_CYC_XWR_DP_SEC :
                       code_internal ? `TBOD_CYC_XWR_DP_INT : `TBOD_CYC_XWR_DP_EXT;
    end

    // ==========================================================================
    // Sequencer
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state       <= ST_OPC;
            opc         <= 8'h00;
            got         <= 2'h0;
            cnt         <= 3'h0;
            fetch_ready <= 1'b1;
            pc_step     <= 1'b0;
            op_class    <= `TBOD_OP_NONE;
            reg_sel     <= 3'h0;
            op_len      <= 2'h1;
            op_cycles   <= 3'h1;
            operand1    <= 8'h00;
            operand2    <= 8'h00;
            issue       <= 1'b0;
            busy        <= 1'b0;
        end
        else if (clk_en)
        begin
            issue   <= 1'b0;
            pc_step <= 1'b0;
            case (state)
                ST_OPC:
                begin
                    if (fetch_valid)
                    begin
                        // program counter passes each taken byte
                        pc_step     <= 1'b1;
                        opc         <= fetch_byte;
                        fetch_ready <= 1'b0;
                        busy        <= 1'b1;
                        state       <= ST_DEC;
                    end
                end
                ST_DEC:
                begin
                    op_class  <= t_class;
                    op_len    <= t_len;
                    op_cycles <= next_cyc;
                    // low opcode bits pick register, bit 0 for indirect
                    reg_sel   <= opc[2:0];
                    got       <= 2'h1;
                    if (!t_valid)
                    begin
                        // Opcodes outside this group pass as one-byte, one-clock
                        op_class    <= `TBOD_OP_NONE;
                        op_cycles   <= 3'h1;
                        issue       <= 1'b1;
                        fetch_ready <= 1'b1;
                        busy        <= 1'b0;
                        state       <= ST_OPC;
                    end
                    else if (t_len == 2'h1)
                    begin
                        cnt   <= next_cyc;
                        issue <= 1'b1;
                        state <= ST_EXEC;
                    end
                    else
                    begin
                        fetch_ready <= 1'b1;
                        cnt         <= next_cyc;
                        state       <= ST_OPND;
                    end
                end
                ST_OPND:
                begin
                    if (fetch_valid)
                    begin
                        // operands taken in order after the opcode
                        pc_step <= 1'b1;
                        if (got == 2'h1)
                            operand1 <= fetch_byte;
                        else
                            operand2 <= fetch_byte;
                        got <= got + 2'h1;
                        if (got + 2'h1 == op_len)
                        begin
                            fetch_ready <= 1'b0;
                            issue       <= 1'b1;
                            state       <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC:
                begin
                    // Hold busy for the stated clock count after issue; the decode clock is not counted
                    if (cnt <= 3'h1)
                    begin
                        fetch_ready <= 1'b1;
                        busy        <= 1'b0;
                        state       <= ST_OPC;
                    end
                    else
                        cnt <= cnt - 3'h1;
                end
                default:
                    state <= ST_OPC;
            endcase
        end
    end

endmodule // tbod_decoder

// File: logic/tbod_map.vh
// Opcode, length and cycle constants for the transfer and branch opcode decoder
// Behaviour
// - 0xE8-0xEF load accumulator from working register, one byte, one clock.
// - 0xE5 load accumulator from direct byte, two bytes, two clocks.
// - 0xE6-0xE7 load accumulator indirect through R0/R1, one byte, two clocks.
// - 0x74 load accumulator with immediate byte, two bytes, two clocks.
// - 0xF8-0xFF copy accumulator to working register, one byte, one clock.
// - 0xA8-0xAF copy direct byte to working register, two bytes, three clocks.
// - 0x85 copy direct byte to direct byte, three bytes, three clocks.
// - 0x90 load 16-bit constant into data pointer, three bytes, three clocks.
// - 0x93 read code at data pointer plus accumulator, one byte, five clocks.
// - 0x83 read code at program counter plus accumulator, one byte, four clocks.
// - 0xE0 read external data at data pointer, two clocks for both spaces.
// - 0xF2/0xF3 external write: off-core 4 internal code else 5, secondary 3.
// - 0xF0 external write: off-core 3 internal code else 4, secondary 2.
// - 0xC0 push three clocks, 0xD0 pop two clocks, both two bytes.
// - 0xD6-0xD7 swap low nibble with indirect byte, one byte, three clocks.
// - 0x73 jump to accumulator plus data pointer, one byte, five clocks.
// - 0x60 branch if accumulator zero, 0x70 if nonzero; two bytes, four clocks.
// - 0x40 branch if carry set, 0x50 if clear; two bytes, three clocks.
// - 0x10 test bit, clear and branch if set; three bytes, five clocks.
// - 0xB5 compare accumulator with direct byte, branch if unequal; 3 bytes, 5 clocks.
// - 0xB8-0xBF compare register with immediate, branch if unequal; 3 bytes, 4 clocks.
// - 0xD8-0xDF decrement register, branch if nonzero; two bytes, four clocks.
`ifndef TBOD_MAP_VH
`define TBOD_MAP_VH

// ==========================================================================
// Operation classes
`define TBOD_OP_NONE      5'h00
`define TBOD_OP_MOV_A_RN  5'h01
`define TBOD_OP_MOV_A_DIR 5'h02
`define TBOD_OP_MOV_A_IND 5'h03
`define TBOD_OP_MOV_A_IMM 5'h04
`define TBOD_OP_MOV_RN_A  5'h05
`define TBOD_OP_MOV_RN_DIR 5'h06
`define TBOD_OP_MOV_DIR_DIR 5'h07
`define TBOD_OP_LOAD_DP   5'h08
`define TBOD_OP_CODE_DP   5'h09
`define TBOD_OP_CODE_PC   5'h0A
`define TBOD_OP_XRD_DP    5'h0B
`define TBOD_OP_XWR_RI    5'h0C
`define TBOD_OP_XWR_DP    5'h0D
`define TBOD_OP_PUSH      5'h0E
`define TBOD_OP_POP       5'h0F
`define TBOD_OP_XCHD      5'h10
`define TBOD_OP_JMP_IND   5'h11
`define TBOD_OP_JZ        5'h12
`define TBOD_OP_JNZ       5'h13
`define TBOD_OP_JC        5'h14
`define TBOD_OP_JNC       5'h15
`define TBOD_OP_JBC       5'h16
`define TBOD_OP_CJNE_DIR  5'h17
`define TBOD_OP_CJNE_RN   5'h18
`define TBOD_OP_DJNZ_RN   5'h19

// ==========================================================================
// Cycle counts that depend on the data space
`define TBOD_CYC_XWR_RI_INT  3'h4
`define TBOD_CYC_XWR_RI_EXT  3'h5
`define TBOD_CYC_XWR_RI_SEC  3'h3
`define TBOD_CYC_XWR_DP_INT  3'h3
`define TBOD_CYC_XWR_DP_EXT  3'h4
`define TBOD_CYC_XWR_DP_SEC  3'h2

`endif

// File: logic/tbod_table.v
// Registered opcode table: class, length and base cycle count per opcode
`timescale 1ns/1ps
`include "tbod_map.vh"

module tbod_table
(
    input  wire       sys_clk,
    input  wire       rst_b,
    input  wire       clk_en,
    input  wire       load,
    input  wire [7:0] opcode,
    output reg  [4:0] op_class,
    output reg  [1:0] op_len,
    output reg  [2:0] op_cyc,
    output reg        op_valid
);

    reg [4:0] c;
    reg [1:0] l;
    reg [2:0] y;

    // ==========================================================================
    // Decode
    always @*
    begin
        c = `TBOD_OP_NONE;
        l = 2'h1;
        y = 3'h1;
        casez (opcode)
            8'b1110_1???: begin c = `TBOD_OP_MOV_A_RN; l = 2'h1; y = 3'h1; end
            8'hE5: begin c = `TBOD_OP_MOV_A_DIR; l = 2'h2; y = 3'h2; end
            8'b1110_011?: begin c = `TBOD_OP_MOV_A_IND; l = 2'h1; y = 3'h2; end
            8'h74: begin c = `TBOD_OP_MOV_A_IMM; l = 2'h2; y = 3'h2; end
            8'b1111_1???: begin c = `TBOD_OP_MOV_RN_A; l = 2'h1; y = 3'h1; end
            8'b1010_1???: begin c = `TBOD_OP_MOV_RN_DIR; l = 2'h2; y = 3'h3; end
            8'h85: begin c = `TBOD_OP_MOV_DIR_DIR; l = 2'h3; y = 3'h3; end
            8'h90: begin c = `TBOD_OP_LOAD_DP; l = 2'h3; y = 3'h3; end
            8'h93: begin c = `TBOD_OP_CODE_DP; l = 2'h1; y = 3'h5; end
            8'h83: begin c = `TBOD_OP_CODE_PC; l = 2'h1; y = 3'h4; end
            8'hE0: begin c = `TBOD_OP_XRD_DP; l = 2'h1; y = 3'h2; end
            8'b1111_001?: begin c = `TBOD_OP_XWR_RI; l = 2'h1; y = 3'h5; end
            8'hF0: begin c = `TBOD_OP_XWR_DP; l = 2'h1; y = 3'h4; end
            8'hC0: begin c = `TBOD_OP_PUSH; l = 2'h2; y = 3'h3; end
            8'hD0: begin c = `TBOD_OP_POP; l = 2'h2; y = 3'h2; end
            8'b1101_011?: begin c = `TBOD_OP_XCHD; l = 2'h1; y = 3'h3; end
            8'h73: begin c = `TBOD_OP_JMP_IND; l = 2'h1; y = 3'h5; end
            8'h60: begin c = `TBOD_OP_JZ; l = 2'h2; y = 3'h4; end
            8'h70: begin c = `TBOD_OP_JNZ; l = 2'h2; y = 3'h4; end
            8'h40: begin c = `TBOD_OP_JC; l = 2'h2; y = 3'h3; end
            8'h50: begin c = `TBOD_OP_JNC; l = 2'h2; y = 3'h3; end
            8'h10: begin c = `TBOD_OP_JBC; l = 2'h3; y = 3'h5; end
            8'hB5: begin c = `TBOD_OP_CJNE_DIR; l = 2'h3; y = 3'h5; end
            8'b1011_1???: begin c = `TBOD_OP_CJNE_RN; l = 2'h3; y = 3'h4; end
            8'b1101_1???: begin c = `TBOD_OP_DJNZ_RN; l = 2'h2; y = 3'h4; end
            default: begin c = `TBOD_OP_NONE; l = 2'h1; y = 3'h1; end
        endcase
    end

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_class <= `TBOD_OP_NONE;
            op_len   <= 2'h1;
            op_cyc   <= 3'h1;
            op_valid <= 1'b0;
        end
        else if (clk_en && load)
        begin
            op_class <= c;
            op_len   <= l;
            op_cyc   <= y;
            op_valid <= (c != `TBOD_OP_NONE);
        end
    end

endmodule // tbod_table

// File: tb/tbod_decoder_bench.sv
// Self-checking testbench for the transfer and branch opcode decoder
`timescale 1ns/1ps
`include "tbod_map.vh"
// ==========
// Bench top
module tbod_decoder_bench;
    logic       sys_clk, rst_b, clk_en, code_internal, target_secondary;
    logic       fetch_valid, fetch_ready, pc_step, issue, busy;
    logic [7:0] fetch_byte, operand1, operand2;
    logic [4:0] op_class;
    logic [2:0] reg_sel, op_cycles;
    logic [1:0] op_len;
    int         bad_count, total_checks, m;
    tbod_decoder tbod_decoder_i (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .code_internal(code_internal),
        .target_secondary(target_secondary), .fetch_ready(fetch_ready), .pc_step(pc_step),
        .op_class(op_class), .reg_sel(reg_sel), .op_len(op_len), .op_cycles(op_cycles),
        .operand1(operand1), .operand2(operand2), .issue(issue), .busy(busy));
    tbod_fetch_model tbod_fetch_model_i (.sys_clk(sys_clk), .clk_en(clk_en),
        .fetch_ready(fetch_ready), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));
    task automatic chk(input string name, input logic [7:0] seen, want);
        total_checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, want, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bytes already queued; waits are bounded since a hung decoder must not stall the run
    task automatic finish_op(input logic [7:0] opc, input logic [4:0] cls,
                             input logic [1:0] len, input logic [2:0] cyc,
                             input logic [7:0] a, b);
        int n, steps;
        steps = 0;
        for (n = 0; n < 20 && issue !== 1'b1; n++)
        begin
            @(negedge sys_clk);
            steps += int'(pc_step === 1'b1);
        end
        if (n == 20)
        begin
            bad_count++;
            wrap_up();
        end
        chk("class", {3'h0, op_class}, {3'h0, cls});
        chk("steps", 8'(steps), {6'h00, len});
        chk("len", {6'h00, op_len}, {6'h00, len});
        chk("cycles", {5'h00, op_cycles}, {5'h00, cyc});
        chk("reg", {5'h00, reg_sel}, {5'h00, opc[2:0]});
        if (len > 2'h1)
            chk("op1", operand1, a);
        if (len > 2'h2)
            chk("op2", operand2, b);
        // Issue stands one clock; ready returns op_cycles clocks after issue
        @(negedge sys_clk);
        chk("issue pulse", {7'h00, issue}, 8'h00);
        for (n = 0; n < 20 && !(fetch_ready === 1'b1 && busy === 1'b0); n++)
            @(negedge sys_clk);
        if (n == 20)
        begin
            bad_count++;
            wrap_up();
        end
        chk("exec clocks", 8'(n + 1), {5'h00, cyc});
    endtask
    task automatic run_op(input logic [7:0] opc, input logic [4:0] cls, input logic [1:0] len,
                          input logic [2:0] cyc, input logic [7:0] a = 8'h5A, b = 8'hC3);
        tbod_fetch_model_i.load(opc);
        if (len > 2'h1)
            tbod_fetch_model_i.load(a);
        if (len > 2'h2)
            tbod_fetch_model_i.load(b);
        finish_op(opc, cls, len, cyc, a, b);
    endtask
    task automatic sc_moves;
        run_op(8'hE8, `TBOD_OP_MOV_A_RN, 2'h1, 3'h1);
        run_op(8'hEF, `TBOD_OP_MOV_A_RN, 2'h1, 3'h1);
        run_op(8'hE5, `TBOD_OP_MOV_A_DIR, 2'h2, 3'h2);
        run_op(8'hE7, `TBOD_OP_MOV_A_IND, 2'h1, 3'h2);
        run_op(8'h74, `TBOD_OP_MOV_A_IMM, 2'h2, 3'h2, 8'hFF);
        run_op(8'hF8, `TBOD_OP_MOV_RN_A, 2'h1, 3'h1);
        run_op(8'hAF, `TBOD_OP_MOV_RN_DIR, 2'h2, 3'h3, 8'h00);
        run_op(8'h85, `TBOD_OP_MOV_DIR_DIR, 2'h3, 3'h3, 8'h12, 8'h34);
        run_op(8'h90, `TBOD_OP_LOAD_DP, 2'h3, 3'h3, 8'hAB, 8'hCD);
    endtask
    task automatic sc_code_stack;
        run_op(8'h93, `TBOD_OP_CODE_DP, 2'h1, 3'h5);
        run_op(8'h83, `TBOD_OP_CODE_PC, 2'h1, 3'h4);
        run_op(8'hC0, `TBOD_OP_PUSH, 2'h2, 3'h3);
        run_op(8'hD0, `TBOD_OP_POP, 2'h2, 3'h2);
        run_op(8'hD6, `TBOD_OP_XCHD, 2'h1, 3'h3);
    endtask
    // external data with internal code, with external code, and with secondary target
    task automatic sc_xdata;
        logic [2:0] ri_cyc, dp_cyc;
        for (m = 0; m < 3; m++)
        begin
            code_internal = (m == 0);
            target_secondary = (m == 2);
            ri_cyc = (m == 0) ? 3'h4 : (m == 1) ? 3'h5 : 3'h3;
            dp_cyc = (m == 0) ? 3'h3 : (m == 1) ? 3'h4 : 3'h2;
            run_op(8'hF2, `TBOD_OP_XWR_RI, 2'h1, ri_cyc);
            run_op(8'hF3, `TBOD_OP_XWR_RI, 2'h1, ri_cyc);
            run_op(8'hF0, `TBOD_OP_XWR_DP, 2'h1, dp_cyc);
            run_op(8'hE0, `TBOD_OP_XRD_DP, 2'h1, 3'h2);
        end
    endtask
    task automatic sc_branch;
        run_op(8'h73, `TBOD_OP_JMP_IND, 2'h1, 3'h5);
        run_op(8'h60, `TBOD_OP_JZ, 2'h2, 3'h4);
        run_op(8'h70, `TBOD_OP_JNZ, 2'h2, 3'h4);
        run_op(8'h40, `TBOD_OP_JC, 2'h2, 3'h3);
        run_op(8'h50, `TBOD_OP_JNC, 2'h2, 3'h3);
        run_op(8'h10, `TBOD_OP_JBC, 2'h3, 3'h5, 8'h81, 8'hFE);
        run_op(8'hB5, `TBOD_OP_CJNE_DIR, 2'h3, 3'h5);
        run_op(8'hB8, `TBOD_OP_CJNE_RN, 2'h3, 3'h4);
        run_op(8'hDF, `TBOD_OP_DJNZ_RN, 2'h2, 3'h4);
    endtask
    // opcodes outside this group pass as one byte, one clock
    task automatic sc_other;
        run_op(8'h00, `TBOD_OP_NONE, 2'h1, 3'h1);
        run_op(8'h24, `TBOD_OP_NONE, 2'h1, 3'h1);
    endtask
    task automatic sc_freeze;
        int k;
        clk_en = 1'b0;
        tbod_fetch_model_i.load(8'hE9);
        // Looked at every clock, since a decoder that ignores the enable finishes within four
        for (k = 0; k < 4; k++)
        begin
            @(negedge sys_clk);
            chk("frozen step", {7'h00, pc_step}, 8'h00);
            chk("frozen busy", {7'h00, busy}, 8'h00);
        end
        clk_en = 1'b1;
        finish_op(8'hE9, `TBOD_OP_MOV_A_RN, 2'h1, 3'h1, 8'h00, 8'h00);
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial
    begin
        rst_b = 1'b0;
        clk_en = 1'b1;
        code_internal = 1'b1;
        target_secondary = 1'b0;
        bad_count = 0;
        total_checks = 0;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        sc_moves();
        sc_code_stack();
        sc_xdata();
        sc_branch();
        sc_other();
        sc_freeze();
        wrap_up();
    end
endmodule // tbod_decoder_bench

// File: tb/tbod_decoder_sva.sv
// Port checker for the transfer and branch opcode decoder
`timescale 1ns/1ps
`include "tbod_map.vh"
// ==========
// Checker
module tbod_decoder_chk
(
    input wire       sys_clk,
    input wire       rst_b,
    input wire       clk_en,
    input wire       fetch_valid,
    input wire [7:0] fetch_byte,
    input wire       code_internal,
    input wire       target_secondary,
    input wire       fetch_ready,
    input wire       pc_step,
    input wire [4:0] op_class,
    input wire [2:0] reg_sel,
    input wire [1:0] op_len,
    input wire [2:0] op_cycles,
    input wire [7:0] operand1,
    input wire [7:0] operand2,
    input wire       issue,
    input wire       busy
);
    wire take = clk_en && fetch_ready && fetch_valid;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_opcode; take && !busy; endsequence
    // Ready may already stand with issue when the opcode is outside this group
    sequence s_finish; issue ##[0:6] (fetch_ready && !busy); endsequence
    a_step_after_take: assert property (take |=> pc_step)
        else $error("byte taken without step");
    a_step_refused: assert property (clk_en && !fetch_ready |=> !pc_step)
        else $error("step on refused byte");
    a_ready_drops: assert property (s_opcode |=> busy && !fetch_ready)
        else $error("ready kept after opcode");
    a_op_bound: assert property (s_opcode |-> ##[2:6] s_finish)
        else $error("instruction not finished in time");
    a_issue_timing: assert property (issue |-> (op_len == 2'h1) ? $past(pc_step) : pc_step)
        else $error("issue not after last byte");
    a_rn_load: assert property (issue && op_class == `TBOD_OP_MOV_A_RN
        |-> op_len == 2'h1 && op_cycles == 3'h1) else $error("register load timing");
    a_code_dp: assert property (issue && op_class == `TBOD_OP_CODE_DP
        |-> op_len == 2'h1 && op_cycles == 3'h5) else $error("code read timing");
    a_xwr_sec: assert property (issue && op_class == `TBOD_OP_XWR_DP && target_secondary
        |-> op_cycles == 3'h2) else $error("secondary write timing");
endmodule // tbod_decoder_chk
bind tbod_decoder tbod_decoder_chk tbod_decoder_chk_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .clk_en(clk_en), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
    .code_internal(code_internal), .target_secondary(target_secondary),
    .fetch_ready(fetch_ready), .pc_step(pc_step), .op_class(op_class), .reg_sel(reg_sel),
    .op_len(op_len), .op_cycles(op_cycles), .operand1(operand1), .operand2(operand2),
    .issue(issue), .busy(busy));

// File: tb/tbod_fetch_model.sv
// Fetch-side model that offers program bytes to the decoder
`timescale 1ns/1ps
// ==========
// Fetch model
module tbod_fetch_model
(
    input  wire logic       sys_clk,
    input  wire logic       clk_en,
    input  wire logic       fetch_ready,
    output logic            fetch_valid,
    output logic      [7:0] fetch_byte
);
    logic [7:0] q[$];
    logic       took = 1'b0;
    // An empty line shows a changing pattern so a stale byte is never reused
    task automatic show;
        fetch_valid = (q.size() != 0);
        fetch_byte  = fetch_valid ? q[0] : ~fetch_byte;
    endtask
    task automatic load(input logic [7:0] b);
        q.push_back(b);
        show();
    endtask
    initial
    begin
        fetch_byte  = 8'h00;
        fetch_valid = 1'b0;
    end
    always @(posedge sys_clk)
        took <= clk_en && fetch_ready && fetch_valid;
    always @(negedge sys_clk)
    begin
        if (took)
            void'(q.pop_front());
        show();
    end
endmodule // tbod_fetch_model
